/* File: logic/lfm_pkg.sv */
package lfm_pkg;
  // Clock rate and time figures
  localparam int CLK_HZ = 10_000_000;
  localparam int T_GND_FILT_MS = 20;
  localparam int T_TEST_US = 300;
  localparam int T_I2C_MS = 500;
  localparam int T_BOCP_MS = 110;
  localparam int T_REC_MS = 100;
  localparam int SYNC_MIN_HZ = 75_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int TEST_CYC = T_TEST_US * (CLK_HZ / 1_000_000);
  // Longest sync period, rounded down
  localparam int SYNC_MAX_CYC = CLK_HZ / SYNC_MIN_HZ;
  localparam int CW = 23;
  // Register byte offsets
  localparam logic [7:0] A_STATUS = 8'h00;
  localparam logic [7:0] A_MASK = 8'h04;
  localparam logic [7:0] A_CTRL = 8'h08;
  localparam logic [7:0] A_CHAN = 8'h0C;
  localparam logic [7:0] A_STATE = 8'h10;
  // Status bit positions
  localparam int NF = 17;
  localparam int B_LED = 0;
  localparam int B_UNUSED = 1;
  localparam int B_I2C = 2;
  localparam int B_LOCK = 3;
  localparam int B_VOVP = 4;
  localparam int B_CORE = 5;
  localparam int B_VOCP = 6;
  localparam int B_PUMP = 7;
  localparam int B_PARTS = 8;
  localparam int B_SYNC = 9;
  localparam int B_CRC = 10;
  localparam int B_OVPL = 11;
  localparam int B_OVPH = 12;
  localparam int B_BOCP = 13;
  localparam int B_CFG = 14;
  localparam int B_MODE = 15;
  localparam int B_FREQ = 16;
  // Flags that raise the interrupt
  localparam logic [NF-1:0] IRQ_BITS = 17'h037FF;
  // Reset values
  localparam logic [NF-1:0] MASK_RST = 17'h00000;
  localparam logic [3:0] STR_RST = 4'hF;
  // Control bit positions
  localparam int C_GROUP = 0;
  typedef enum {ST_STBY, ST_RUN, ST_REC, ST_LATCH} lfm_state_t;
  typedef enum {G_IDLE, G_FILT, G_TEST} lfm_gnd_t;
endpackage : lfm_pkg

/* File: logic/lfm_top.sv */
module lfm_top
  import lfm_pkg::*;
#(
  parameter int GND_FILT_CYC = lfm_pkg::T_GND_FILT_MS * lfm_pkg::CYC_PER_MS,
  parameter int I2C_TO_CYC = lfm_pkg::T_I2C_MS * lfm_pkg::CYC_PER_MS,
  parameter int BOCP_CYC = lfm_pkg::T_BOCP_MS * lfm_pkg::CYC_PER_MS,
  parameter int REC_CYC = lfm_pkg::T_REC_MS * lfm_pkg::CYC_PER_MS
)(
  input wire logic i_clk, // 10 MHz clock
  input wire logic i_rst_n, // Sync reset, power-on
  input wire logic i_psel, // APB select
  input wire logic i_penable, // APB enable
  input wire logic i_pwrite, // APB write
  input wire logic [7:0] i_paddr, // APB byte address
  input wire logic [31:0] i_pwdata, // APB write data
  output logic [31:0] o_prdata, // APB read data
  output logic o_pready, // APB ready
  output logic o_pslverr, // APB error
  input wire logic [3:0] i_led_short, // Output above short threshold
  input wire logic [3:0] i_led_window, // Output in normal window
  input wire logic [3:0] i_ground_short_flag, // Output below ground threshold
  input wire logic [3:0] i_led_hdrm_low, // Output below headroom
  input wire logic [3:0] i_led_hdrm_hys, // Above headroom plus hysteresis
  input wire logic i_boost_at_min, // Adaptive boost at minimum
  input wire logic i_vin_lockout, // Lockout pin low
  input wire logic i_vin_ovp, // Input over 43 V
  input wire logic i_core_low, // Core supply low
  input wire logic i_vin_ocp, // Sense voltage over 220 mV
  input wire logic i_pump_bad, // Pump level abnormal
  input wire logic i_pump_missing, // Pump parts missing
  input wire logic i_boost_sync_input, // External sync clock pin
  input wire logic i_crc_bad, // Defaults load failed
  input wire logic i_fb_ovp_low, // Feedback over low limit
  input wire logic i_fb_ovp_high, // Feedback or discharge over high
  input wire logic i_fb_uvp, // Feedback under limit
  input wire logic i_cfg_res_bad, // String config resistor bad
  input wire logic i_mode_res_bad, // Mode resistor bad
  input wire logic i_freq_res_bad, // Frequency resistor bad
  input wire logic i_unused_not_gnd, // Unused output not grounded
  input wire logic i_i2c_open, // Serial transaction open
  input wire logic i_enable, // Enable pin
  input wire logic i_bright_nz, // Brightness above zero
  input wire logic i_init_done, // Initialization complete
  output logic [3:0] o_string_en, // PWM enable per string
  output logic [3:0] o_loop_en, // String in boost loop
  output logic [3:0] o_test_current, // Test current per channel
  output logic o_boost_on, // Boost allowed
  output logic o_boost_hold, // Boost switching paused
  output logic o_fet_on, // Power-line FET on
  output logic o_pump_off, // Charge pump disabled
  output logic o_i2c_reset, // Serial block reset pulse
  output logic o_use_internal_clk, // Internal boost clock
  output logic o_spread_on, // Spread spectrum on
  output logic o_cfg_default, // Four strings, 200 mA default
  output logic o_mode_default, // Phase-shift, default address
  output logic o_freq_default, // 400 kHz, 305 Hz default
  output logic o_int // Interrupt request
);
  import lfm_pkg::*;

  localparam int NA = 40; // Count of asynchronous inputs
  logic [NA-1:0] a_s1; // First sync stage
  logic [NA-1:0] a_s2; // Second sync stage
  logic [3:0] sh, win, gl, hl, hh; // Synced channel comparators
  logic b_min, lock, vovp, core, vocp, pbad, pmis, sync_in;
  logic crc, ovpl, ovph, uvp, cfgb, modeb, freqb, unus;
  logic i2co, en, bnz, initd;

  // Two-stage synchroniser for all pin inputs
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      a_s1 <= '0;
      a_s2 <= '0;
    end
    else
    begin
      a_s1 <= {i_led_short, i_led_window, i_ground_short_flag, i_led_hdrm_low,
               i_led_hdrm_hys, i_boost_at_min, i_vin_lockout, i_vin_ovp,
               i_core_low, i_vin_ocp, i_pump_bad, i_pump_missing,
               i_boost_sync_input, i_crc_bad, i_fb_ovp_low, i_fb_ovp_high,
               i_fb_uvp, i_cfg_res_bad, i_mode_res_bad, i_freq_res_bad,
               i_unused_not_gnd, i_i2c_open, i_enable, i_bright_nz,
               i_init_done};
      a_s2 <= a_s1;
    end
  end
  assign {sh, win, gl, hl, hh, b_min, lock, vovp, core, vocp, pbad, pmis,
          sync_in, crc, ovpl, ovph, uvp, cfgb, modeb, freqb, unus, i2co,
          en, bnz, initd} = a_s2;

  lfm_state_t state, next_state; // Operating state
  lfm_gnd_t gph; // Ground test phase
  logic [CW-1:0] gcnt; // Ground filter and test timer
  logic [1:0] gch; // Channel under ground test
  logic [CW-1:0] i2c_cnt; // Open transaction timer
  logic [CW-1:0] bocp_cnt; // Feedback low timer
  logic [CW-1:0] rec_cnt; // Recovery timer
  logic [7:0] sync_cnt; // Cycles since sync edge
  logic sync_d, sync_ok, en_d, init_d; // Edge history
  logic [3:0] str_en; // Strings still in service
  logic [NF-1:0] status; // Sticky flags
  logic [NF-1:0] mask; // Interrupt mask
  logic [NF-1:0] ev; // Flag set events
  logic [NF-1:0] w1c; // Software clear bits
  logic ctrl_group; // Grouped-channel mode
  logic flag_short, flag_gnd; // Power-held detail flags
  logic [3:0] flag_ch; // Power-held per-channel flags
  logic [3:0] short_ev; // Short found per channel
  logic gnd_fault; // Ground fault confirmed
  logic run; // Monitoring active
  logic hold; // Supply condition forces standby
  logic rec_ev; // Event that enters recovery
  logic [1:0] gsel; // First channel below ground
  logic gany; // Any in-service channel low
  logic wr, rd; // APB access strobes

  assign run = (state == ST_RUN);
  assign hold = lock | vovp | core;

  // Short detection per channel
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      short_ev[i] = run && str_en[i] &&
        ((sh[i] && |(win & ~(4'h1 << i))) ||
         (ctrl_group && b_min && hh[i]));
    end
  end

  // Lowest in-service channel below ground threshold
  always_comb
  begin
    gsel = 2'h0;
    gany = 1'b0;
    for (int i = 3; i >= 0; i--)
    begin
      if (gl[i] && str_en[i])
      begin
        gsel = 2'(i);
        gany = 1'b1;
      end
    end
  end

  // Confirmed when output still low at end of test
  assign gnd_fault = (gph == G_TEST) && (gcnt == CW'(TEST_CYC - 1))
                     && hl[gch];

  // Ground filter and test-current sequencer
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      gph <= G_IDLE;
      gcnt <= '0;
      gch <= 2'h0;
    end
    else if (!run)
    begin
      gph <= G_IDLE;
      gcnt <= '0;
    end
    else
    begin
      case (gph)
        G_IDLE:
        begin
          gcnt <= '0;
          gch <= gsel;
          if (gany)
            gph <= G_FILT;
        end
        G_FILT:
        begin
          // Low must persist on the same channel
          if (!gl[gch])
            gph <= G_IDLE;
          else if (gcnt == CW'(GND_FILT_CYC - 1))
          begin
            gph <= G_TEST;
            gcnt <= '0;
          end
          else
            gcnt <= gcnt + 1'b1;
        end
        G_TEST:
        begin
          if (gcnt == CW'(TEST_CYC - 1))
            gph <= G_IDLE;
          else
            gcnt <= gcnt + 1'b1;
        end
        default: gph <= G_IDLE;
      endcase
    end
  end

  // Strings in service, restored only at power-up
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      str_en <= STR_RST;
    else
      str_en <= str_en & ~short_ev;
  end

  // Detail flags held until power is removed
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      flag_short <= 1'b0;
      flag_gnd <= 1'b0;
      flag_ch <= 4'h0;
    end
    else
    begin
      if (|short_ev)
        flag_short <= 1'b1;
      if (gnd_fault)
        flag_gnd <= 1'b1;
      flag_ch <= flag_ch | short_ev |
        (gnd_fault ? (4'h1 << gch) : 4'h0);
    end
  end

  // Open bus transaction watchdog
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      i2c_cnt <= '0;
      o_i2c_reset <= 1'b0;
    end
    else
    begin
      o_i2c_reset <= 1'b0;
      if (!i2co)
        i2c_cnt <= '0;
      else if (i2c_cnt == CW'(I2C_TO_CYC - 1))
      begin
        i2c_cnt <= '0;
        o_i2c_reset <= 1'b1;
      end
      else
        i2c_cnt <= i2c_cnt + 1'b1;
    end
  end

  // Feedback-low timer
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n || !run || !uvp)
      bocp_cnt <= '0;
    else if (bocp_cnt != CW'(BOCP_CYC - 1))
      bocp_cnt <= bocp_cnt + 1'b1;
  end

  // Sync clock watch and fallback
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      sync_d <= 1'b0;
      // No edge seen yet, so an early enable never finds a valid clock
      sync_cnt <= 8'(SYNC_MAX_CYC);
      sync_ok <= 1'b0;
      en_d <= 1'b0;
    end
    else
    begin
      sync_d <= sync_in;
      en_d <= en;
      if (sync_in != sync_d)
        sync_cnt <= 8'h00;
      else if (sync_cnt != 8'(SYNC_MAX_CYC))
        sync_cnt <= sync_cnt + 1'b1;
      // Valid clock must be running when enabled
      if (!en)
        sync_ok <= 1'b0;
      else if (en && !en_d)
        sync_ok <= (sync_cnt != 8'(SYNC_MAX_CYC));
      else if (sync_cnt == 8'(SYNC_MAX_CYC))
        sync_ok <= 1'b0;
    end
  end

  // Events that set sticky flags
  always_comb
  begin
    ev = '0;
    ev[B_LED] = |short_ev | gnd_fault;
    ev[B_UNUSED] = initd && !init_d && unus;
    ev[B_I2C] = (i2c_cnt == CW'(I2C_TO_CYC - 1));
    ev[B_LOCK] = lock;
    ev[B_VOVP] = vovp;
    ev[B_CORE] = core;
    ev[B_VOCP] = run && vocp;
    ev[B_PUMP] = (run && pbad) || pmis;
    ev[B_PARTS] = pmis;
    ev[B_SYNC] = sync_ok && (sync_cnt == 8'(SYNC_MAX_CYC));
    ev[B_CRC] = initd && !init_d && crc;
    ev[B_OVPL] = run && ovpl;
    ev[B_OVPH] = run && ovph;
    ev[B_BOCP] = (bocp_cnt == CW'(BOCP_CYC - 1));
    ev[B_CFG] = initd && !init_d && cfgb;
    ev[B_MODE] = initd && !init_d && modeb;
    ev[B_FREQ] = initd && !init_d && freqb;
  end

  // Faults that force recovery; missing parts do not
  assign rec_ev = gnd_fault || ev[B_VOCP] || ev[B_OVPH] || ev[B_BOCP]
                  || (run && pbad && !pmis);

  // Next operating state
  always_comb
  begin
    next_state = state;
    case (state)
      ST_STBY:
        if (!hold && en && bnz)
          next_state = ST_RUN;
      ST_RUN:
        if (!en || hold)
          next_state = ST_STBY;
        else if (rec_ev)
          next_state = ST_REC;
        else if (str_en == 4'h0)
          next_state = ST_LATCH;
      ST_REC:
        if (hold)
          next_state = ST_STBY;
        else if (rec_cnt == CW'(REC_CYC - 1) && !ovph)
          next_state = ST_STBY;
      ST_LATCH:
        if (!en)
          next_state = ST_STBY;
      default: next_state = ST_STBY;
    endcase
  end

  // State register and recovery timer
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      state <= ST_STBY;
      rec_cnt <= '0;
    end
    else
    begin
      state <= next_state;
      if (state != ST_REC)
        rec_cnt <= '0;
      else if (rec_cnt != CW'(REC_CYC - 1))
        rec_cnt <= rec_cnt + 1'b1;
    end
  end

  // Power stage and channel drive outputs
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_boost_on <= 1'b0;
      o_fet_on <= 1'b0;
      o_boost_hold <= 1'b0;
      o_string_en <= 4'h0;
      o_loop_en <= 4'h0;
      o_test_current <= 4'h0;
    end
    else
    begin
      o_boost_on <= (next_state == ST_RUN);
      o_fet_on <= (next_state == ST_RUN);
      o_boost_hold <= ovpl;
      o_loop_en <= str_en & ~short_ev;
      if (next_state == ST_RUN && bnz)
        o_string_en <= str_en & ~short_ev &
          ((gph == G_TEST) ? ~(4'h1 << gch) : 4'hF);
      else
        o_string_en <= 4'h0;
      o_test_current <= (run && gph == G_TEST && !gnd_fault) ?
        (4'h1 << gch) : 4'h0;
    end
  end

  // Init-time samples and fallback selections
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      init_d <= 1'b0;
      o_cfg_default <= 1'b0;
      o_mode_default <= 1'b0;
      o_freq_default <= 1'b0;
      o_pump_off <= 1'b0;
      o_use_internal_clk <= 1'b1;
      o_spread_on <= 1'b0;
    end
    else
    begin
      init_d <= initd;
      if (initd && !init_d)
      begin
        o_cfg_default <= cfgb;
        o_mode_default <= modeb;
        o_freq_default <= freqb;
      end
      if (pmis)
        o_pump_off <= 1'b1;
      o_use_internal_clk <= !sync_ok;
      if (!sync_ok)
        o_spread_on <= sync_in;
    end
  end

  assign wr = i_psel && i_penable && !o_pready && i_pwrite;
  assign rd = i_psel && i_penable && !o_pready && !i_pwrite;
  assign w1c = (wr && i_paddr == A_STATUS) ? i_pwdata[NF-1:0] : '0;

  // Sticky flags: a set in the clear cycle wins
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      status <= '0;
    else
      status <= (status & ~w1c) | ev;
  end

  // Software-written mask and control
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      mask <= MASK_RST;
      ctrl_group <= 1'b0;
    end
    else if (wr && i_paddr == A_MASK)
      mask <= i_pwdata[NF-1:0];
    else if (wr && i_paddr == A_CTRL)
      ctrl_group <= i_pwdata[C_GROUP];
  end

  // Interrupt from unmasked raising flags
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      o_int <= 1'b0;
    else
      o_int <= |(status & IRQ_BITS & ~mask);
  end

  // APB slave: one wait state, error on unmapped
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h00000000;
    end
    else
    begin
      o_pready <= i_psel && i_penable && !o_pready;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h00000000;
      if (wr || rd)
      begin
        case (i_paddr)
          A_STATUS: o_prdata <= 32'(status);
          A_MASK: o_prdata <= 32'(mask);
          A_CTRL: o_prdata <= 32'(ctrl_group);
          A_CHAN: o_prdata <= {26'h0, flag_gnd, flag_short, flag_ch};
          A_STATE: o_prdata <= {28'h0, str_en};
          default: o_pslverr <= 1'b1;
        endcase
      end
    end
  end
endmodule : lfm_top

/* File: test/lfm_top_sva.sv */
module lfm_chk (
  input wire logic i_clk, // Clock
  input wire logic i_rst_n, // Reset
  input wire logic i_psel, // Select
  input wire logic i_penable, // Enable
  input wire logic i_fb_ovp_low, // Ovp low pin
  input wire logic [31:0] o_prdata, // Read data
  input wire logic o_pready, // Ready
  input wire logic o_pslverr, // Error
  input wire logic [3:0] o_string_en, // Strings
  input wire logic [3:0] o_test_current, // Test current
  input wire logic o_boost_on, // Boost
  input wire logic o_fet_on, // Line FET
  input wire logic o_pump_off, // Pump off
  input wire logic o_i2c_reset, // Bus reset
  input wire logic o_use_internal_clk, // Internal clock
  input wire logic o_boost_hold, // Switching paused
  input wire logic o_int // Interrupt
);
  timeunit 1ns;
  timeprecision 1ns;
  // Access phase always gets exactly one wait state
  a_one_wait: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_psel && i_penable && !o_pready |=> o_pready) else $error("ready late");
  a_ready_pulse: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_pready |=> !o_pready) else $error("ready too long");
  a_err_ready: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_pslverr |-> o_pready) else $error("error without ready");
  a_rdata_idle: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !o_pready |-> o_prdata == 32'h0) else $error("read data outside answer");
  // A channel under test current never has its PWM on
  a_test_no_pwm: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (o_test_current & o_string_en) == 4'h0) else $error("test with pwm");
  a_power_pair: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    o_boost_on == o_fet_on) else $error("boost and fet differ");
  a_bus_reset_pulse: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    o_i2c_reset |=> !o_i2c_reset) else $error("bus reset too long");
  a_pump_sticky: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    o_pump_off |=> o_pump_off) else $error("pump came back");
  a_hold_follows: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_fb_ovp_low [*4] |-> o_boost_hold) else $error("no switching pause");
  // Reset leaves interrupt and boost off with the internal clock chosen
  a_reset_quiet: assert property (@(posedge i_clk)
    !i_rst_n |=> !o_int && !o_boost_on && o_use_internal_clk) else $error("reset");
endmodule : lfm_chk
bind lfm_top lfm_chk i_chk (.*);

/* File: test/lfm_host.sv */
module lfm_host (
  input wire logic i_clk, // Clock
  input wire logic i_pready, // Ready
  input wire logic i_pslverr, // Error
  input wire logic [31:0] i_prdata, // Read data
  output logic o_psel = 1'b0, // Select
  output logic o_penable = 1'b0, // Enable
  output logic o_pwrite = 1'b0, // Write
  output logic [7:0] o_paddr = 8'h00, // Address
  output logic [31:0] o_pwdata = 32'h0 // Write data
);
  timeunit 1ns;
  timeprecision 1ns;
  // One transfer; request held until ready is sampled, ok low on no answer
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e, output logic ok);
    int n;
    o_psel <= 1'b1;
    o_pwrite <= w;
    o_paddr <= a;
    o_pwdata <= d;
    @(posedge i_clk);
    o_penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge i_clk);
      n++;
    end
    while (i_pready !== 1'b1 && n < 20);
    q = i_prdata;
    e = i_pslverr;
    ok = i_pready === 1'b1;
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    @(posedge i_clk);
  endtask : xfer
endmodule : lfm_host

/* File: test/lfm_bench.sv */
module lfm_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import lfm_pkg::*;
  localparam int GF = 50; // Short ground filter
  localparam int RC = 30; // Short recovery
`define CHK(nm, x, s) \
  begin n_compared++; if ((s) !== (x)) begin errors++; \
  $display("wrong value %s exp %0h got %0h", nm, x, s); end end
  logic i_clk = 1'b0; // Clock
  logic i_rst_n = 1'b0; // Reset
  logic i_psel, i_penable, i_pwrite, o_pready, o_pslverr; // Bus strobes
  logic [7:0] i_paddr; // Address
  logic [31:0] i_pwdata, o_prdata, q; // Data and last read
  logic e; // Last error
  logic [3:0] i_led_short = 4'h0, i_led_window = 4'hF, i_ground_short_flag = 4'h0;
  logic [3:0] i_led_hdrm_low = 4'h0, i_led_hdrm_hys = 4'h0; // Headroom
  logic [3:0] o_string_en, o_loop_en, o_test_current; // String outputs
  logic [9:0] flt = 10'h000; // Row fault inputs
  logic i_vin_lockout, i_vin_ovp, i_core_low, i_vin_ocp, i_pump_bad, i_pump_missing;
  logic i_fb_ovp_low, i_fb_ovp_high, i_fb_uvp, i_i2c_open; // Row faults
  logic i_boost_at_min = 1'b0, i_crc_bad = 1'b0, i_cfg_res_bad = 1'b0;
  logic i_mode_res_bad = 1'b0, i_freq_res_bad = 1'b0, i_unused_not_gnd = 1'b0;
  logic i_enable = 1'b0, i_bright_nz = 1'b0, i_init_done = 1'b0; // Control
  logic i_boost_sync_input = 1'b0, syr = 1'b0, syl = 1'b0; // Sync pin
  logic o_boost_on, o_boost_hold, o_fet_on, o_pump_off, o_i2c_reset; // Power
  logic o_use_internal_clk, o_spread_on, o_cfg_default, o_mode_default;
  logic o_freq_default, o_int; // Defaults, interrupt
  logic i2c_pulse = 1'b0; // Bus reset pulse seen
  int errors = 0;
  int n_compared = 0;
  typedef struct {int hold; logic [NF-1:0] st; logic off;} lfm_row_t;
  // Fault held for hold cycles, expected flags, power off at end
  lfm_row_t rows [10] = '{
    '{20, 17'h1 << B_LOCK, 1'b1},
    '{20, 17'h1 << B_VOVP, 1'b1},
    '{20, 17'h1 << B_CORE, 1'b1},
    '{20, 17'h1 << B_VOCP, 1'b1},
    '{20, 17'h1 << B_PUMP, 1'b1},
    '{20, 17'h1 << B_OVPL, 1'b0},
    '{20, 17'h1 << B_OVPH, 1'b1},
    '{40, 17'h1 << B_BOCP, 1'b1},
    '{50, 17'h1 << B_I2C, 1'b0},
    '{20, (17'h1 << B_PARTS) | (17'h1 << B_PUMP), 1'b0}
  };
  assign {i_pump_missing, i_i2c_open, i_fb_uvp, i_fb_ovp_high, i_fb_ovp_low} = flt[9:5];
  assign {i_pump_bad, i_vin_ocp, i_core_low, i_vin_ovp, i_vin_lockout} = flt[4:0];
  lfm_top #(.GND_FILT_CYC(GF), .I2C_TO_CYC(40), .BOCP_CYC(30), .REC_CYC(RC)) i_dut (.*);
  lfm_host i_host (.i_clk, .i_pready(o_pready), .i_pslverr(o_pslverr),
    .i_prdata(o_prdata), .o_psel(i_psel), .o_penable(i_penable),
    .o_pwrite(i_pwrite), .o_paddr(i_paddr), .o_pwdata(i_pwdata));
  initial forever #50 i_clk = ~i_clk;
  // Sync pin toggles every cycle while running, else holds a level
  always @(posedge i_clk) i_boost_sync_input <= syr ? ~i_boost_sync_input : syl;
  // Remembers that the serial block reset pulse was given
  always @(posedge i_clk) if (o_i2c_reset) i2c_pulse <= 1'b1;
  task automatic report_and_stop();
    $display("compared %0d mismatched %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic late();
    errors++;
    $display("wrong value wait exp answer got timeout");
    report_and_stop();
  endtask : late
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic ok;
    i_host.xfer(w, a, d, q, e, ok);
    if (!ok) late();
  endtask : bus
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask : tick
  // Waits a bounded time for the power stage; n gives the cycles taken
  task automatic wait_run(output int n);
    n = 0;
    while (o_boost_on !== 1'b1 && n < 300)
    begin
      tick(1);
      n++;
    end
    if (n >= 300) late();
  endtask : wait_run
  // Ground short on channel 0; v says the output stays low under test
  task automatic gnd_try(input logic v);
    int n;
    i_led_hdrm_low <= {3'b000, v};
    i_ground_short_flag <= 4'h1;
    n = 0;
    while (o_test_current !== 4'h1 && n < GF + 20)
    begin
      tick(1);
      n++;
    end
    if (n >= GF + 20) late();
    `CHK("filter", 1'b1, n >= GF)
    `CHK("string off", 1'b0, o_string_en[0])
    tick(TEST_CYC + 4);
    `CHK("after test", {~v, 4'h0}, {o_boost_on, o_test_current})
    i_ground_short_flag <= 4'h0;
    i_led_hdrm_low <= 4'h0;
    bus(0, A_CHAN, 0);
    `CHK("chan", v ? 32'h21 : 32'h0, q)
    wait_run(n);
    if (v) `CHK("restart", 1'b1, n >= RC - 15 && n <= RC)
    $display("test ground %0d finished", v);
  endtask : gnd_try
  initial
  begin
    int n;
    tick(16);
    i_rst_n <= 1'b1;
    i_init_done <= 1'b1;
    i_enable <= 1'b1;
    i_bright_nz <= 1'b1;
    tick(2);
    foreach (rows[k])
    begin
      wait_run(n);
      flt <= 10'h001 << k;
      tick(rows[k].hold);
      `CHK("power", {2{~rows[k].off}}, {o_boost_on, o_fet_on})
      `CHK("hold", rows[k].st[B_OVPL], o_boost_hold)
      flt <= 10'h000;
      wait_run(n);
      bus(0, A_STATUS, 0);
      `CHK("status", 32'(rows[k].st), q)
      `CHK("irq", |(rows[k].st & ~MASK_RST & IRQ_BITS), o_int)
      bus(1, A_STATUS, q);
      tick(2);
      `CHK("irq clear", 1'b0, o_int)
      $display("test row %0d finished", k);
    end
    `CHK("pump off", 1'b1, o_pump_off)
    `CHK("bus reset", 1'b1, i2c_pulse)
    gnd_try(1'b0);
    gnd_try(1'b1);
    bus(0, A_STATUS, 0);
    `CHK("summary", 33'h100000001, {o_int, q})
    bus(1, A_STATUS, q);
    bus(0, A_CHAN, 0);
    `CHK("chan held", 33'h21, {o_int, q})
    // Second reset with every init-time check failing
    {i_cfg_res_bad, i_mode_res_bad, i_freq_res_bad, i_crc_bad, i_unused_not_gnd} <= 5'h1F;
    i_init_done <= 1'b0;
    i_enable <= 1'b0;
    i_rst_n <= 1'b0;
    tick(16);
    i_rst_n <= 1'b1;
    tick(2);
    `CHK("outs", 4'h1, {o_int, o_boost_on, o_pump_off, o_use_internal_clk})
    bus(0, A_CHAN, 0);
    `CHK("chan reset", 32'h0, q)
    bus(0, A_STATE, 0);
    `CHK("strings", 32'(STR_RST), q)
    bus(0, A_MASK, 0);
    `CHK("mask", 32'(MASK_RST), q)
    bus(1, 8'h20, 32'hFFFFFFFF);
    `CHK("slverr", 1'b1, e)
    bus(0, 8'h20, 0);
    `CHK("unmapped", 33'h100000000, {e, q})
    i_init_done <= 1'b1;
    tick(6);
    `CHK("defaults", 3'h7, {o_cfg_default, o_mode_default, o_freq_default})
    {i_cfg_res_bad, i_mode_res_bad, i_freq_res_bad, i_crc_bad, i_unused_not_gnd} <= 5'h0;
    bus(0, A_STATUS, 0);
    `CHK("init flags", 32'((1 << B_CFG) | (1 << B_MODE) | (1 << B_FREQ) | (1 << B_CRC) |
      (1 << B_UNUSED)), q)
    `CHK("init irq", 1'b1, o_int)
    bus(1, A_STATUS, 32'h1FFFF);
    tick(2);
    `CHK("init clear", 1'b0, o_int)
    $display("test reset finished");
    syr <= 1'b1;
    tick(5);
    i_enable <= 1'b1;
    tick(30);
    `CHK("ext clk", 1'b0, o_use_internal_clk)
    syr <= 1'b0;
    syl <= 1'b1;
    tick(150);
    `CHK("int clk", 2'h3, {o_use_internal_clk, o_spread_on})
    bus(0, A_STATUS, 0);
    `CHK("sync flag", 33'h100000200, {o_int, q})
    bus(1, A_STATUS, q);
    syl <= 1'b0;
    tick(6);
    `CHK("spread", 1'b0, o_spread_on)
    $display("test sync finished");
    i_led_short <= 4'h2;
    i_led_window <= 4'hD;
    tick(6);
    `CHK("drop", 8'hDD, {o_string_en, o_loop_en})
    bus(0, A_CHAN, 0);
    `CHK("short", 33'h100000012, {o_int, q})
    i_led_short <= 4'h0;
    i_led_window <= 4'hF;
    bus(1, A_STATUS, 32'h1);
    bus(1, A_MASK, 32'h1);
    i_led_short <= 4'h1;
    i_led_window <= 4'hE;
    tick(6);
    bus(0, A_STATUS, 0);
    `CHK("masked", 33'h1, {o_int, q})
    i_led_short <= 4'h0;
    bus(1, A_CTRL, 32'h1);
    i_boost_at_min <= 1'b1;
    i_led_hdrm_hys <= 4'h4;
    tick(6);
    `CHK("group", 4'h8, o_string_en)
    i_led_hdrm_hys <= 4'h8;
    tick(6);
    `CHK("latch", 5'h0, {o_string_en, o_boost_on})
    $display("test shorts finished");
    report_and_stop();
  end
endmodule : lfm_bench
